// File: hdl/eips_top.sv
// encoder input pin select: routes pins or comparator 1 to decoder home and index
// assumes pin and comparator inputs are asynchronous; decoder runs on aclk
`timescale 1ns/1ps
`default_nettype none

module eips_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  // selectable sources: index n is pin number n for pin codes
  input  wire logic        first_comparator_output,
  input  wire logic [127:0] remappable_in_pin,
  // to the quadrature decoder
  output var  logic        encoder_home_input,
  output var  logic        encoder_index_input
);

  eips_pkg::eips_state_type state;
  eips_pkg::eips_state_type next_state;
  logic [127:0] source_vec;
  logic         aw_hold;
  logic [3:0]   aw_addr_hold;
  logic         w_hold;
  logic [15:0]  w_data_hold;
  logic [1:0]   w_strb_hold;

  // true when a code has a wired source behind it
  function automatic logic code_implemented(input logic [6:0] code);
    logic ok;
    ok = 1'b0;
    if (code <= 7'h04 || code == 7'h06 || code == 7'h07 || code == 7'h08 || code == 7'h09) begin
      ok = 1'b1;
    end else if (code == 7'h14 || code == 7'h18 || code == 7'h19 || code == 7'h1b || code == 7'h1c) begin
      ok = 1'b1;
    end else if ((code >= 7'h20 && code <= 7'h2f) || (code >= 7'h33 && code <= 7'h3a)) begin
      ok = 1'b1;
    end else if (code == eips_pkg::code_highest) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : code_implemented

  // the source vector: code zero ground, code one comparator, else pin of that number if wired, low if not
  genvar gi;
  generate
    for (gi = 0; gi < eips_pkg::num_codes; gi++) begin : g_src
      if (gi == 0) begin : g_gnd
        assign source_vec[gi] = 1'b0;
      end else if (gi == 1) begin : g_cmp
        assign source_vec[gi] = first_comparator_output;
      end else begin : g_pin
        // pin in numeric order, unwired codes low
        assign source_vec[gi] = code_implemented(7'(gi)) ? remappable_in_pin[gi] : 1'b0;
      end
    end
  endgenerate

  // pending write halves held until the write response is taken; address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      aw_addr_hold <= 4'h0;
      w_hold       <= 1'b0;
      w_data_hold  <= 16'h0000;
      w_strb_hold  <= 2'h0;
    end else begin
      if (s_axi_awvalid && state.awready) begin
        aw_hold      <= 1'b1;
        aw_addr_hold <= s_axi_awaddr[3:0];
      end else if (state.bvalid && s_axi_bready) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && state.wready) begin
        w_hold      <= 1'b1;
        w_data_hold <= s_axi_wdata[15:0];
        w_strb_hold <= s_axi_wstrb[1:0];
      end else if (state.bvalid && s_axi_bready) begin
        w_hold <= 1'b0;
      end
    end
  end

  // next state: bus handshakes, register update, synchronisers
  always_comb begin
    logic [15:0] merged;
    merged     = state.sel;
    next_state = state;
    // one write at a time: ready only while that half is not held
    next_state.awready = !aw_hold && !(s_axi_awvalid && state.awready);
    next_state.wready  = !w_hold && !(s_axi_wvalid && state.wready);
    if (aw_hold && w_hold && !state.bvalid) begin
      next_state.bvalid = 1'b1;
      if (aw_addr_hold == eips_pkg::sel_reg_offset) begin
        if (w_strb_hold[0]) merged[7:0] = w_data_hold[7:0];
        if (w_strb_hold[1]) merged[15:8] = w_data_hold[15:8];
        next_state.sel   = merged & eips_pkg::sel_write_mask;
        next_state.bresp = eips_pkg::resp_okay;
      end else if (aw_addr_hold == eips_pkg::status_offset) begin
        next_state.bresp = eips_pkg::resp_okay;  // read-only, write dropped
      end else begin
        next_state.bresp = eips_pkg::resp_slverr;
      end
    end else if (state.bvalid && s_axi_bready) begin
      next_state.bvalid  = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready  = 1'b1;
    end
    // reads: one-cycle accept, data in the following cycle
    next_state.arready = !state.rvalid && !(s_axi_arvalid && state.arready);
    if (s_axi_arvalid && state.arready) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = 32'h0000_0000;
      next_state.rresp  = eips_pkg::resp_okay;
      if (s_axi_araddr[3:0] == eips_pkg::sel_reg_offset && s_axi_araddr[31:4] == 28'h0) begin
        next_state.rdata = {16'h0000, state.sel};
      end else if (s_axi_araddr[3:0] == eips_pkg::status_offset && s_axi_araddr[31:4] == 28'h0) begin
        next_state.rdata = {30'h0, state.home_out, state.index_out};
      end else begin
        next_state.rresp = eips_pkg::resp_slverr;
      end
    end else if (state.rvalid && s_axi_rready) begin
      next_state.rvalid  = 1'b0;
      next_state.arready = 1'b1;
    end
    // select, two-flop synchronise, then an output flop; trades three cycles of latency for safety
    next_state.home_sync  = {state.home_sync[0],
                             source_vec[state.sel[eips_pkg::home_lsb +: eips_pkg::code_width]]};
    next_state.index_sync = {state.index_sync[0],
                             source_vec[state.sel[eips_pkg::index_lsb +: eips_pkg::code_width]]};
    next_state.home_out   = state.home_sync[1];
    next_state.index_out  = state.index_sync[1];
  end

  // the state register, apart from the write holds; reset selects ground on both inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state         <= '0;
      state.sel     <= eips_pkg::sel_reset_value;
      state.awready <= 1'b1;
      state.wready  <= 1'b1;
      state.arready <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready       = state.awready;
  assign s_axi_wready        = state.wready;
  assign s_axi_bvalid        = state.bvalid;
  assign s_axi_bresp         = state.bresp;
  assign s_axi_arready       = state.arready;
  assign s_axi_rvalid        = state.rvalid;
  assign s_axi_rdata         = state.rdata;
  assign s_axi_rresp         = state.rresp;
  assign encoder_home_input  = state.home_out;
  assign encoder_index_input = state.index_out;

endmodule : eips_top
`default_nettype wire

// File: hdl/eips_pkg.sv
// package for the encoder input pin select block
// assumes a 32-bit axi4-lite register bus and a 7-bit selector code space
package eips_pkg;
  // register map
  localparam logic [3:0]  sel_reg_offset   = 4'h0;  // encoder_input_select
  localparam logic [3:0]  status_offset    = 4'h4;  // live synchronised inputs, read only
  localparam logic [15:0] sel_reset_value  = 16'h0000;
  // field layout
  localparam int          home_lsb         = 8;
  localparam int          index_lsb        = 0;
  localparam int          code_width       = 7;
  localparam logic [15:0] sel_write_mask   = 16'h7f7f;
  // source codes
  localparam logic [6:0]  code_ground      = 7'h00;
  localparam logic [6:0]  code_comparator1 = 7'h01;
  localparam logic [6:0]  code_highest     = 7'h79;
  localparam int          num_codes        = 128;
  // axi responses
  localparam logic [1:0]  resp_okay        = 2'h0;
  localparam logic [1:0]  resp_slverr      = 2'h2;
  // state of the block
  typedef struct packed {
    logic [15:0] sel;
    logic [1:0]  home_sync;
    logic [1:0]  index_sync;
    logic        home_out;
    logic        index_out;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } eips_state_type;
endpackage : eips_pkg

// File: sim/eips_dec_model.sv
// decoder front end model: captures home and index once per clock
// assumes both inputs come from eips_top on aclk
`timescale 1ns/1ps
`default_nettype none
module eips_dec_model (
  // selector outputs in, captured pair out
  input  wire logic       aclk,
  input  wire logic       encoder_home_input,
  input  wire logic       encoder_index_input,
  output var  logic [1:0] seen
);
  // one capture flop, as the decoder samples
  always_ff @(posedge aclk) seen <= {encoder_home_input, encoder_index_input};
endmodule : eips_dec_model
`default_nettype wire

// File: sim/eips_chk.sv
// checker for eips_top: bus handshakes, read padding, reset state
// assumes it is bound to eips_top on one aclk domain
`timescale 1ns/1ps
`default_nettype none
module eips_chk (
  // watched ports
  input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic        s_axi_rready, encoder_home_input, encoder_index_input,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a write taken whole at one edge owes bvalid two edges on
  sequence s_wtake; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  property p_blat; s_wtake |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  property p_rpad; s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[7]; endproperty
  property p_awdrop; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  property p_ardrop; s_axi_arvalid && s_axi_arready |=> !s_axi_arready; endproperty
  property p_rstout; $rose(aresetn) |-> !encoder_home_input && !encoder_index_input; endproperty
  a_blat: assert property (p_blat) else $error("bvalid late");
  a_bdone: assert property (p_bdone) else $error("bvalid held");
  a_rlat: assert property (p_rlat) else $error("rvalid late");
  a_rdone: assert property (p_rdone) else $error("rvalid held");
  a_rpad: assert property (p_rpad) else $error("reserved bits set");
  a_awdrop: assert property (p_awdrop) else $error("awready held");
  a_ardrop: assert property (p_ardrop) else $error("arready held");
  a_rstout: assert property (p_rstout) else $error("inputs not ground");
endmodule : eips_chk
bind eips_top eips_chk u_eips_chk (.*);
`default_nettype wire

// File: sim/test_encoder_input_pin_select.sv
// bench for eips_top: axi4-lite master, pin and comparator drive
// assumes the checker and decoder model are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module test_encoder_input_pin_select;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic first_comparator_output, encoder_home_input, encoder_index_input;
  logic [127:0] remappable_in_pin;
  logic [31:0]  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, got;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, seen, got_resp;
  int           fails, samples_checked;
  eips_top u_eips_top (.*);
  eips_dec_model u_eips_dec_model (.*);
  task automatic complete_run;
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) $display("[ERR] %0t got %h want %h", $time, g, e);
    if (g !== e) fails++;
  endtask : chk
  // write (w high) or read; valids drop once taken, ready waits for the answer
  // handshakes are judged on the settled values half a cycle before the edge,
  // so the bench never races the design's own update at that edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int   n;
    logic aw_go;
    logic w_go;
    logic ar_go;
    logic resp_go;
    resp_go = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    for (n = 0; n < 64 && !resp_go; n++) begin
      @(negedge aclk);
      aw_go   = s_axi_awvalid && s_axi_awready;
      w_go    = s_axi_wvalid && s_axi_wready;
      ar_go   = s_axi_arvalid && s_axi_arready;
      resp_go = w ? s_axi_bvalid : s_axi_rvalid;
      if (resp_go) begin
        got      = w ? {30'h0, s_axi_bresp} : s_axi_rdata;
        got_resp = w ? s_axi_bresp : s_axi_rresp;
      end
      @(posedge aclk);
      if (aw_go) s_axi_awvalid <= 1'b0;
      if (w_go) s_axi_wvalid <= 1'b0;
      if (ar_go) s_axi_arvalid <= 1'b0;
      if (resp_go) {s_axi_bready, s_axi_rready} <= 2'b00;
    end
    if (!resp_go) begin
      chk(32'h0, 32'h1);
      complete_run;
    end
  endtask : xfer
  // reset value, reserved bits, unmapped word answers slverr to a write and a read
  task automatic t_regs;
    xfer(1'b0, 32'h0, 32'h0);
    chk(got, 32'h0);
    xfer(1'b1, 32'h0, 32'hffffffff);
    xfer(1'b0, 32'h0, 32'h0);
    chk(got, 32'h7f7f);
    xfer(1'b1, 32'h8, 32'h0);
    chk(got, {30'h0, eips_pkg::resp_slverr});
    xfer(1'b0, 32'h8, 32'h0);
    chk(got, 32'h0);
    chk({30'h0, got_resp}, {30'h0, eips_pkg::resp_slverr});
  endtask : t_regs
  // ground, comparator, top pin, middle pin, unused codes, comparator low
  task automatic t_route;
    logic [31:0] sel [6] = '{32'h0100, 32'h0001, 32'h7979, 32'h0033, 32'h3005, 32'h0100};
    logic [1:0]  want [6] = '{2'b10, 2'b01, 2'b11, 2'b01, 2'b00, 2'b00};
    for (int i = 0; i < 6; i++) begin
      first_comparator_output <= (i != 5);
      remappable_in_pin <= (i == 3) ? 128'h1 << 51 : ((i == 2) ? 128'h1 << 121 : '1);
      xfer(1'b1, 32'h0, sel[i]);
      repeat (5) @(posedge aclk);
      chk({30'h0, seen}, {30'h0, want[i]});
      xfer(1'b0, 32'h4, 32'h0);
      chk(got, {30'h0, want[i]});
    end
  endtask : t_route
  // 4 ns clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // reset held 20 cycles, then the scenarios
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, remappable_in_pin, first_comparator_output} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_route;
    complete_run;
  end
endmodule : test_encoder_input_pin_select
`default_nettype wire
